/* ccscp_pkg.sv */
// shared constants and types of the clock chip serial configuration host
package ccscp_pkg;

  // ---------------------------------------------------------------
  // register offsets and fields of the host's own apb registers
  // ---------------------------------------------------------------
  localparam logic [7:0] CCSCP_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CCSCP_OFF_WORD     = 8'h04;
  localparam logic [7:0] CCSCP_OFF_STATUS   = 8'h08;
  localparam int         CCSCP_CTRL_MODE_LSB = 0;
  localparam int         CCSCP_CTRL_HALF_LSB = 8;
  localparam int         CCSCP_ST_BUSY       = 0;
  localparam int         CCSCP_ST_DONE       = 1;
  localparam int         CCSCP_ST_CAL        = 2;
  localparam int         CCSCP_ST_ORDER      = 3;
  localparam int         CCSCP_ST_ADDR_LSB   = 8;

  // ---------------------------------------------------------------
  // word layout and link counts
  // ---------------------------------------------------------------
  localparam int         CCSCP_WORD_BITS    = 32;
  localparam int         CCSCP_ADDR_BITS    = 5;
  localparam logic [5:0] CCSCP_LAST_BIT     = 6'h1f;
  localparam logic [1:0] CCSCP_EXTRA_LAST   = 2'h2;
  localparam logic [4:0] CCSCP_CAL_ADDR     = 5'h1e;

  // ---------------------------------------------------------------
  // timing: link half period derived from the pclk rate
  // ---------------------------------------------------------------
  localparam int         CCSCP_CLK_PERIOD_NS  = 25;
  localparam int         CCSCP_LINK_PERIOD_NS = 200;
  localparam int         CCSCP_LINK_HALF_CYC  =
    (CCSCP_LINK_PERIOD_NS / 2 + CCSCP_CLK_PERIOD_NS - 1) / CCSCP_CLK_PERIOD_NS;
  localparam logic [7:0] CCSCP_HALF_RST       = 8'(CCSCP_LINK_HALF_CYC);

  // ---------------------------------------------------------------
  // modes, states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CCSCP_MODE_NORMAL      = 2'h0,
    CCSCP_MODE_EXTRA_AFTER = 2'h1,
    CCSCP_MODE_EXTRA_LE_HI = 2'h2
  } ccscp_mode_type;
  localparam ccscp_mode_type CCSCP_MODE_RST = CCSCP_MODE_NORMAL;

  typedef enum logic [6:0] {
    CCSCP_IDLE     = 7'h01,
    CCSCP_SHIFT_LO = 7'h02,
    CCSCP_SHIFT_HI = 7'h04,
    CCSCP_LE_HIGH  = 7'h08,
    CCSCP_LE_LOW   = 7'h10,
    CCSCP_EXTRA_LO = 7'h20,
    CCSCP_EXTRA_HI = 7'h40
  } ccscp_st_type;

  typedef struct packed {
    logic sclk;
    logic le;
  } ccscp_lines_type;

endpackage

/* ccscp_clk_div.sv */
// half period tick generator for the serial clock line
`timescale 1ns/1ps
module ccscp_clk_div
  import ccscp_pkg::*;
#(
  parameter int HALF_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  input  wire logic [HALF_W-1:0] half,
  output logic                   tick
);

  typedef struct packed {
    logic [HALF_W-1:0] cnt;
  } ccscp_div_type;

  ccscp_div_type r;
  ccscp_div_type n;

  // a half of zero behaves as one so the link never stalls
  always_comb begin
    n    = r;
    tick = 1'b0;
    if (!run) begin
      n.cnt = '0;
    end else if (r.cnt + 1'b1 >= half) begin
      n.cnt = '0;
      tick  = 1'b1;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

/* ccscp_shifter.sv */
// msb first output shift register, zero filled behind the last bit
`timescale 1ns/1ps
module ccscp_shifter
  import ccscp_pkg::*;
#(
  parameter int WIDTH = CCSCP_WORD_BITS
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             load,
  input  wire logic             shift,
  input  wire logic [WIDTH-1:0] din,
  output logic                  msb
);

  typedef struct packed {
    logic [WIDTH-1:0] sh;
  } ccscp_sh_type;

  ccscp_sh_type r;
  ccscp_sh_type n;

  // zero fill leaves the data line low once the word is out
  always_comb begin
    n = r;
    if (load) begin
      n.sh = din;
    end else if (shift) begin
      n.sh = {r.sh[WIDTH-2:0], 1'b0};
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign msb = r.sh[WIDTH-1];

endmodule

/* ccscp_host.sv */
// apb controlled host that programs the clock chip over its three wire port
`timescale 1ns/1ps
module ccscp_host
  import ccscp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             serial_clock_line,
  output logic             serial_data_line,
  output logic             load_enable_line
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ccscp_st_type    st;
    ccscp_mode_type  mode;
    ccscp_mode_type  fmode;
    logic [7:0]      half;
    logic [31:0]     word;
    logic [5:0]      bit_cnt;
    logic [1:0]      extra_cnt;
    logic            done;
    logic            cal;
    logic            order_warn;
    logic            have_addr;
    logic [4:0]      last_addr;
    ccscp_lines_type lines;
    logic [31:0]     rdata;
  } ccscp_state_type;

  ccscp_state_type r;
  ccscp_state_type n;

  logic tick;
  logic load;
  logic shift;
  logic start;
  logic finish;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic busy;

  assign busy = (r.st != CCSCP_IDLE);

  // ---------------------------------------------------------------
  // link timing and output shifter
  // ---------------------------------------------------------------
  ccscp_clk_div #(
    .HALF_W (8)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy),
    .half    (r.half),
    .tick    (tick)
  );

  ccscp_shifter #(
    .WIDTH (CCSCP_WORD_BITS)
  ) u_sh (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (load),
    .shift   (shift),
    .din     (pwdata),
    .msb     (serial_data_line)
  );

  // ---------------------------------------------------------------
  // apb decode, zero wait states
  // ---------------------------------------------------------------
  assign mapped   = (paddr == CCSCP_OFF_CTRL) || (paddr == CCSCP_OFF_WORD) || (paddr == CCSCP_OFF_STATUS);
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign start    = wr_acc && (paddr == CCSCP_OFF_WORD) && !busy;
  assign pready   = 1'b1;
  // a word written while a frame runs is refused rather than queued
  assign pslverr  = psel && penable && (!mapped || (pwrite && (paddr == CCSCP_OFF_WORD) && busy));
  assign prdata   = r.rdata;

  // ---------------------------------------------------------------
  // next state: registers, then the link sequencer
  // ---------------------------------------------------------------
  always_comb begin
    n      = r;
    load   = 1'b0;
    shift  = 1'b0;
    finish = 1'b0;
    // read data captured in setup so it is stable in the access phase
    if (rd_setup) begin
      case (paddr)
        CCSCP_OFF_CTRL: begin
          n.rdata = {16'h0000, r.half, 6'h00, r.mode};
        end
        CCSCP_OFF_WORD: begin
          n.rdata = r.word;
        end
        CCSCP_OFF_STATUS: begin
          n.rdata = {19'h00000, r.last_addr, 4'h0, r.order_warn, r.cal, r.done, busy};
        end
        default: begin
          n.rdata = 32'h00000000;
        end
      endcase
    end
    // control writes; mode only reaches the link at the next frame start
    if (wr_acc && (paddr == CCSCP_OFF_CTRL)) begin
      n.mode = ccscp_mode_type'(pwdata[CCSCP_CTRL_MODE_LSB +: 2]);
      n.half = pwdata[CCSCP_CTRL_HALF_LSB +: 8];
    end
    // sticky flags cleared by writing one; a set below wins
    if (wr_acc && (paddr == CCSCP_OFF_STATUS)) begin
      if (pwdata[CCSCP_ST_DONE]) begin
        n.done = 1'b0;
      end
      if (pwdata[CCSCP_ST_CAL]) begin
        n.cal = 1'b0;
      end
      if (pwdata[CCSCP_ST_ORDER]) begin
        n.order_warn = 1'b0;
      end
    end
    case (r.st)
      CCSCP_IDLE: begin
        n.lines = '0;
        if (start) begin
          // payload passes untouched: software owns its legality
          n.word      = pwdata;
          load        = 1'b1;
          n.bit_cnt   = 6'h00;
          n.extra_cnt = 2'h0;
          n.fmode     = r.mode;
          n.st        = CCSCP_SHIFT_LO;
          // flag a step back in address order, do not refuse it
          if (r.have_addr && (pwdata[CCSCP_ADDR_BITS-1:0] < r.last_addr)) begin
            n.order_warn = 1'b1;
          end
          n.have_addr = 1'b1;
          n.last_addr = pwdata[CCSCP_ADDR_BITS-1:0];
        end
      end
      CCSCP_SHIFT_LO: begin
        if (tick) begin
          n.lines.sclk = 1'b1;
          n.st         = CCSCP_SHIFT_HI;
        end
      end
      CCSCP_SHIFT_HI: begin
        if (tick) begin
          n.lines.sclk = 1'b0;
          shift        = 1'b1;
          if (r.bit_cnt == CCSCP_LAST_BIT) begin
            n.lines.le = 1'b1;
            n.st       = CCSCP_LE_HIGH;
          end else begin
            n.bit_cnt = r.bit_cnt + 6'h01;
            n.st      = CCSCP_SHIFT_LO;
          end
        end
      end
      CCSCP_LE_HIGH: begin
        if (tick) begin
          if (r.fmode == CCSCP_MODE_EXTRA_LE_HI) begin
            n.st = CCSCP_EXTRA_LO;
          end else begin
            n.lines.le = 1'b0;
            n.st       = CCSCP_LE_LOW;
          end
        end
      end
      CCSCP_LE_LOW: begin
        if (tick) begin
          if (r.fmode == CCSCP_MODE_EXTRA_AFTER) begin
            n.st = CCSCP_EXTRA_LO;
          end else begin
            finish = 1'b1;
          end
        end
      end
      CCSCP_EXTRA_LO: begin
        if (tick) begin
          n.lines.sclk = 1'b1;
          n.st         = CCSCP_EXTRA_HI;
        end
      end
      CCSCP_EXTRA_HI: begin
        if (tick) begin
          n.lines.sclk = 1'b0;
          if (r.extra_cnt != CCSCP_EXTRA_LAST) begin
            n.extra_cnt = r.extra_cnt + 2'h1;
            n.st        = CCSCP_EXTRA_LO;
          end else if (r.lines.le) begin
            // falling edge after the extras so the sync sees new values
            n.lines.le = 1'b0;
            n.fmode    = CCSCP_MODE_NORMAL;
            n.st       = CCSCP_LE_LOW;
          end else begin
            finish = 1'b1;
          end
        end
      end
      default: begin
        n.lines = '0;
        n.st    = CCSCP_IDLE;
      end
    endcase
    // frame end: load enable already low, serial clock low from this edge; flags set over any clear
    if (finish) begin
      n.st   = CCSCP_IDLE;
      n.done = 1'b1;
      if (r.word[CCSCP_ADDR_BITS-1:0] == CCSCP_CAL_ADDR) begin
        n.cal = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.st    <= CCSCP_IDLE;
      r.mode  <= CCSCP_MODE_RST;
      r.fmode <= CCSCP_MODE_RST;
      r.half  <= CCSCP_HALF_RST;
    end else begin
      r <= n;
    end
  end

  assign serial_clock_line = r.lines.sclk;
  assign load_enable_line  = r.lines.le;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic       word_msb;
  logic [4:0] word_addr;
  logic       sclk_q;
  logic [5:0] rise_cnt;
  logic [1:0] hi_cnt;

  assign word_msb  = pwdata[CCSCP_WORD_BITS-1];
  assign word_addr = r.word[CCSCP_ADDR_BITS-1:0];

  // rising edges seen per frame, split by load enable level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q   <= 1'b0;
      rise_cnt <= 6'h00;
      hi_cnt   <= 2'h0;
    end else begin
      sclk_q <= serial_clock_line;
      if (start) begin
        rise_cnt <= 6'h00;
        hi_cnt   <= 2'h0;
      end else if (serial_clock_line && !sclk_q) begin
        if (load_enable_line) begin
          hi_cnt <= hi_cnt + 2'h1;
        end else if (rise_cnt != 6'h3f) begin
          rise_cnt <= rise_cnt + 6'h01;
        end
      end
    end
  end

  a_msb_first_out : assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> (serial_data_line == $past(word_msb)))
    else $error("first data bit is not bit 31");
  a_thirtytwo_bits : assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(load_enable_line) |-> (rise_cnt == 6'h20))
    else $error("latch after a count other than 32 rising edges");
  a_le_low_shift : assert property (
    @(posedge pclk) disable iff (!presetn)
    ((r.st == CCSCP_SHIFT_LO) || (r.st == CCSCP_SHIFT_HI)) |-> !load_enable_line)
    else $error("load enable high while shifting");
  a_data_before_edge : assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(serial_clock_line) |-> $stable(serial_data_line))
    else $error("data changed on the clock rising edge");
  // load enable may move on the very edge that drops the serial clock
  a_le_clock_low : assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(load_enable_line) |-> !serial_clock_line)
    else $error("load enable moved while serial clock high");
  a_extra_le_high : assert property (
    @(posedge pclk) disable iff (!presetn)
    ($fell(load_enable_line) && (r.fmode == CCSCP_MODE_NORMAL) && ($past(r.st) == CCSCP_EXTRA_HI))
    |-> (hi_cnt == 2'h3))
    else $error("load enable fell without three extra rising edges");
  a_extra_after : assert property (
    @(posedge pclk) disable iff (!presetn)
    ($fell(load_enable_line) && (r.fmode == CCSCP_MODE_EXTRA_AFTER))
    |-> !serial_clock_line ##[1:600] $rose(serial_clock_line))
    else $error("no bare extra clock after the latch");
  a_idle_low : assert property (
    @(posedge pclk) disable iff (!presetn)
    ((r.st == CCSCP_IDLE) && !start) |=> (!serial_clock_line && !load_enable_line && !serial_data_line))
    else $error("lines not low when idle");
  a_cal_flag : assert property (
    @(posedge pclk) disable iff (!presetn)
    (finish && (word_addr == CCSCP_CAL_ADDR)) |=> (r.cal && r.done && (r.st == CCSCP_IDLE)))
    else $error("calibration word end not flagged");
endmodule

/* ccscp_dev_model.sv */
// behavioural model of the clock chip's serial configuration port
`timescale 1ns/1ps
module ccscp_dev_model
  import ccscp_pkg::*;
(
  input  wire logic        serial_clock_line,
  input  wire logic        serial_data_line,
  input  wire logic        load_enable_line,
  output logic      [31:0] last_word,
  output int               latch_count,
  output int               cal_count,
  output int               sync_count,
  output int               extra_rises,
  output int               hi_rises,
  output int               short_frames,
  output int               pend_left
);
  logic [31:0] shift_reg;
  logic [26:0] cfg_reg [32];
  logic [26:0] live_reg [8];
  logic [4:0]  addr_reg;
  int          bit_count;
  int          pend_count;

  // extra rising edges still owed before a channel update commits
  assign pend_left = pend_count;

  // ---------------------------------------------------------------
  // power-on state
  // ---------------------------------------------------------------
  initial begin
    shift_reg = 32'h0;
    last_word = 32'h0;
    addr_reg = 5'h1f;
    latch_count = 0;
    cal_count = 0;
    sync_count = 0;
    extra_rises = 0;
    hi_rises = 0;
    short_frames = 0;
    bit_count = 0;
    pend_count = 0;
  end

  // sample data on each rising serial clock; count down pending updates
  always @(posedge serial_clock_line) begin
    shift_reg = {shift_reg[30:0], serial_data_line};
    bit_count++;
    extra_rises++;
    if (load_enable_line) hi_rises++;
    if (pend_count > 0) begin
      pend_count--;
      if (pend_count == 0) live_reg[addr_reg[2:0]] = cfg_reg[addr_reg];
    end
  end

  // latch on rising load enable; address from the last five bits shifted
  always @(posedge load_enable_line) begin
    if (bit_count < 32) short_frames++;
    last_word = shift_reg;
    addr_reg = shift_reg[4:0];
    // loop mode words are only stored; the loops are not modelled
    cfg_reg[addr_reg] = shift_reg[31:5];
    latch_count++;
    bit_count = 0;
    extra_rises = 0;
    hi_rises = 0;
    // payload is not decoded, so every channel write waits conservatively
    pend_count = (addr_reg < 5'h06) ? 3 : 0;
    if (addr_reg == CCSCP_CAL_ADDR) cal_count++;
  end

  // auto sync taken as on: a channel write ends in a sync on the fall
  always @(negedge load_enable_line) begin
    if (addr_reg < 5'h06) begin
      sync_count++;
      live_reg[addr_reg[2:0]] = cfg_reg[addr_reg];
    end
  end
endmodule

/* ccscp_host_tb_top.sv */
// self-checking testbench of the clock chip serial configuration host
`timescale 1ns/1ps
module ccscp_host_tb_top
  import ccscp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, last_word;
  logic        pready, pslverr, sclk, sdata, le, err;
  int          latch_count, cal_count, sync_count, extra_rises, hi_rises, short_frames, pend_left;
  int          miscompares, cmp_count, lc, sc, cc;
  logic [1:0]  row_mode [6] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h2};
  logic [31:0] row_word [6] = '{32'ha5a5_5a40, 32'h0123_4565, 32'hffff_fff0,
                                32'h8000_0018, 32'h0f0f_0f1e, 32'h3c3c_3c1f};

  // ---------------------------------------------------------------
  // clock, design and device model
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ccscp_host u_ccscp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_line(sclk), .serial_data_line(sdata), .load_enable_line(le));

  ccscp_dev_model u_ccscp_dev_model (.serial_clock_line(sclk), .serial_data_line(sdata),
    .load_enable_line(le), .last_word(last_word), .latch_count(latch_count), .cal_count(cal_count),
    .sync_count(sync_count), .extra_rises(extra_rises), .hi_rises(hi_rises), .short_frames(short_frames),
    .pend_left(pend_left));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge; idles one cycle after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    check(err === exp_err, "bus error flag");
  endtask

  // poll status until the frame is over; bounded so a hang is reported
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, CCSCP_OFF_STATUS, 32'h0, 1'b0);
      n++;
    end while (q[CCSCP_ST_BUSY] !== 1'b0 && n < 400);
    check(n < 400, "frame never finished");
  endtask

  // one frame in a given mode and half period, judged at the wire model
  task automatic frame(input logic [1:0] m, input logic [7:0] h, input logic [31:0] w);
    lc = latch_count;
    sc = sync_count;
    cc = cal_count;
    apb(1'b1, CCSCP_OFF_CTRL, {16'h0, h, 6'h0, m}, 1'b0);
    apb(1'b1, CCSCP_OFF_WORD, w, 1'b0);
    wait_idle();
    check(q[CCSCP_ST_DONE] === 1'b1, "done flag");
    check(q[12:8] === w[4:0], "status address");
    check(last_word === w, "word latched");
    check(latch_count == lc + 1, "one latch per word");
    check(extra_rises == ((m == 2'h1 || m == 2'h2) ? 3 : 0), "extra clocks");
    check(pend_left == ((w[4:0] < 5'h06 && m != 2'h1 && m != 2'h2) ? 3 : 0), "update commit");
    check(hi_rises == (m == 2'h2 ? 3 : 0), "clocks with load enable high");
    check(sync_count - sc == int'(w[4:0] < 5'h06), "sync count");
    check(cal_count - cc == int'(w[4:0] == CCSCP_CAL_ADDR), "calibration latch");
    check(q[CCSCP_ST_CAL] === (w[4:0] == CCSCP_CAL_ADDR), "calibration flag");
    check({sclk, sdata, le} === 3'b000, "lines low when idle");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    miscompares = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    check({sclk, sdata, le, prdata} === 35'h0, "outputs in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CCSCP_OFF_CTRL, 32'h0, 1'b0);
    check(q === 32'h0000_0400, "control reset value");
    apb(1'b0, CCSCP_OFF_STATUS, 32'h0, 1'b0);
    check(q === 32'h0, "status reset value");
    // ordinary cases: ascending addresses through every mode
    for (int i = 0; i < 6; i++) begin
      frame(row_mode[i], 8'h04, row_word[i]);
      check(q[CCSCP_ST_ORDER] === 1'b0, "no order warning");
      apb(1'b1, CCSCP_OFF_STATUS, 32'h0000_000e, 1'b0);
    end
    // half period 0 runs as 1; a lower address after 31 warns
    frame(2'h0, 8'h00, 32'h1234_5603);
    check(q[CCSCP_ST_ORDER] === 1'b1, "order warning");
    apb(1'b1, CCSCP_OFF_STATUS, 32'h0000_000e, 1'b0);
    apb(1'b0, CCSCP_OFF_STATUS, 32'h0, 1'b0);
    check(q[3:1] === 3'h0, "sticky flags cleared");
    // a second word while busy is refused and leaves the frame intact
    lc = latch_count;
    apb(1'b1, CCSCP_OFF_WORD, 32'hdead_bee2, 1'b0);
    apb(1'b1, CCSCP_OFF_WORD, 32'h5555_5544, 1'b1);
    wait_idle();
    check(last_word === 32'hdead_bee2, "refused word ignored");
    check(latch_count == lc + 1, "single latch");
    apb(1'b0, CCSCP_OFF_WORD, 32'h0, 1'b0);
    check(q === 32'hdead_bee2, "word readback");
    // unmapped places read zero and flag an error
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    check(q === 32'h0, "unmapped read");
    apb(1'b1, 8'h10, 32'hffff_ffff, 1'b1);
    // reset in mid frame drops the lines; the next frame still lands whole
    apb(1'b1, CCSCP_OFF_CTRL, 32'h0000_0400, 1'b0);
    apb(1'b1, CCSCP_OFF_WORD, 32'h0000_0001, 1'b0);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    check({sclk, sdata, le} === 3'b000, "lines low in mid frame reset");
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CCSCP_OFF_STATUS, 32'h0, 1'b0);
    check(q === 32'h0, "status after mid frame reset");
    frame(2'h0, 8'h04, 32'h0000_0021);
    check(short_frames == 0, "load enable low for all 32 bits");
    final_report();
  end

  // watchdog well beyond the nine whole frames, the one cut by reset and their polling
  initial begin
    #(25 * 30000);
    miscompares++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end
endmodule
